// [logic/tad_map.svh]
// Register offsets, field positions, reset values and timing counts of the tap and activity register bank
`ifndef TAD_MAP_SVH
`define TAD_MAP_SVH
`define TAD_OFS_CFG 8'h38
`define TAD_OFS_STATUS 8'h39
`define TAD_OFS_THS 8'h3a
`define TAD_OFS_LIMIT 8'h3b
`define TAD_OFS_LATENCY 8'h3c
`define TAD_OFS_WINDOW 8'h3d
`define TAD_OFS_WAKE_THS 8'h3e
`define TAD_OFS_WAKE_DUR 8'h3f
`define TAD_BIT_IA 6
`define TAD_BIT_DOUBLE 5
`define TAD_BIT_SINGLE 4
`define TAD_BIT_SIGN 3
`define TAD_BIT_LATCH 7
`define TAD_RST_BYTE 8'h00
`define TAD_RST_FIELD7 7'h00
`define TAD_WAKE_MUL 8
`endif

// [logic/tad_pkg.sv]
// Types shared by the tap and activity register bank
package tad_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tad_bus_t;
	typedef struct packed {
		logic valid;
		logic negative;
		logic [2:0] axis;
	} tad_tap_t;
	typedef enum logic [1:0] {
		TAD_IDLE = 2'b00,
		TAD_GAP = 2'b01,
		TAD_WIN = 2'b11
	} tad_state_t;
endpackage : tad_pkg

// [logic/tad_odr_timer.sv]
// Counts data-rate ticks down from a loaded value and flags expiry
`timescale 1ns/10ps
module tad_odr_timer #(
	parameter int WIDTH = 12
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_tick,
	input wire logic i_load,
	input wire logic [WIDTH-1:0] i_count,
	// Status
	output logic o_busy
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt_reg;
	} tad_tmr_st_t;
	tad_tmr_st_t st_reg;
	tad_tmr_st_t st_next;
	always_comb begin
		st_next = st_reg;
		if (i_load) begin
			st_next.cnt_reg = i_count;
		end else if (i_tick && st_reg.cnt_reg != '0) begin
			st_next.cnt_reg = st_reg.cnt_reg - 1'b1;
		end
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign o_busy = st_reg.cnt_reg != '0;
endmodule : tad_odr_timer

// [logic/tad_wake_timer.sv]
// Activity duration counter: reports when activity has lasted 8N+1 data-rate periods
`timescale 1ns/10ps
`include "tad_map.svh"
module tad_wake_timer (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Inputs
	input wire logic i_tick,
	input wire logic i_active,
	input wire logic [7:0] i_dur,
	// Status
	output logic o_done
);
	typedef struct packed {
		logic [11:0] cnt_reg;
		logic done_reg;
	} tad_wk_st_t;
	tad_wk_st_t st_reg;
	tad_wk_st_t st_next;
	logic [11:0] limit;
	always_comb begin
		limit = 12'(`TAD_WAKE_MUL * i_dur) + 12'h001;
		st_next = st_reg;
		if (!i_active) begin
			st_next.cnt_reg = '0;
			st_next.done_reg = 1'b0;
		end else if (i_tick && !st_reg.done_reg) begin
			st_next.cnt_reg = st_reg.cnt_reg + 12'h001;
			st_next.done_reg = (st_reg.cnt_reg + 12'h001) >= limit;
		end
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign o_done = st_reg.done_reg;
endmodule : tad_wake_timer

// [logic/tad_regs.sv]
// Tap detector and activity register bank with tap sequencing and interrupt output
`timescale 1ns/10ps
`include "tad_map.svh"
module tad_regs (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Register access from the serial interface
	input tad_pkg::tad_bus_t i_bus,
	output logic [7:0] o_rdata,
	// Sensor side
	input wire logic i_odr_tick,
	input tad_pkg::tad_tap_t i_tap,
	input wire logic i_activity,
	// Outputs
	output logic o_tap_irq,
	output logic o_wake,
	output logic [6:0] o_tap_threshold,
	output logic [6:0] o_wake_threshold
);
	import tad_pkg::*;

	typedef struct packed {
		logic [5:0] cfg_reg;
		logic latch_reg;
		logic [6:0] ths_reg;
		logic [6:0] limit_reg;
		logic [7:0] latency_reg;
		logic [7:0] window_reg;
		logic [6:0] wake_ths_reg;
		logic [7:0] wake_dur_reg;
		logic ia_reg;
		logic dbl_reg;
		logic sgl_reg;
		logic sign_reg;
		logic [2:0] axis_reg;
		logic irq_reg;
		logic [7:0] rdata_reg;
		logic [7:0] tap_len_reg;
		logic tap_seen_reg;
		logic tap_neg_reg;
		logic [2:0] tap_axis_reg;
		tad_state_t fsm_reg;
		logic wake_reg;
	} tad_st_t;

	tad_st_t st_reg;
	tad_st_t st_next;
	logic gate_busy;
	logic gate_load;
	logic [8:0] gate_count;
	logic wake_done;
	logic [2:0] single_en;
	logic [2:0] double_en;
	logic [2:0] hit_single;
	logic [2:0] hit_double;
	logic status_rd;
	logic [7:0] status_byte;
	logic tap_end;

	// Per-axis enable bits: cfg = {zd, zs, yd, ys, xd, xs}
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_axis
			assign single_en[g] = st_reg.cfg_reg[2*g];
			assign double_en[g] = st_reg.cfg_reg[2*g+1];
			assign hit_single[g] = st_reg.tap_axis_reg[g] & single_en[g];
			assign hit_double[g] = st_reg.tap_axis_reg[g] & double_en[g];
		end
	endgenerate

	assign status_rd = i_bus.rd && i_bus.addr == `TAD_OFS_STATUS;
	// A tap counts once, as its pulse ends, and only if it lasted no longer than the time limit
	assign tap_end = st_reg.tap_seen_reg && !i_tap.valid && st_reg.tap_len_reg <= {1'b0, st_reg.limit_reg};
	// Status byte assembled from its field positions; bit 7 reads zero
	always_comb begin
		status_byte = `TAD_RST_BYTE;
		status_byte[`TAD_BIT_IA] = st_reg.ia_reg;
		status_byte[`TAD_BIT_DOUBLE] = st_reg.dbl_reg;
		status_byte[`TAD_BIT_SINGLE] = st_reg.sgl_reg;
		status_byte[`TAD_BIT_SIGN] = st_reg.sign_reg;
		status_byte[2:0] = st_reg.axis_reg;
	end

	tad_odr_timer #(
		.WIDTH(9)
	) u_gate (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_tick(i_odr_tick),
		.i_load(gate_load),
		.i_count(gate_count),
		.o_busy(gate_busy)
	);

	tad_wake_timer u_wake (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_tick(i_odr_tick),
		.i_active(i_activity),
		.i_dur(st_reg.wake_dur_reg),
		.o_done(wake_done)
	);

	always_comb begin
		st_next = st_reg;
		gate_load = 1'b0;
		gate_count = '0;
		// Tap duration measured in data-rate periods while the raw tap level is high
		// Sign and axes are captured while the pulse lasts, since they are used as it ends
		if (i_tap.valid) begin
			st_next.tap_seen_reg = 1'b1;
			st_next.tap_neg_reg = i_tap.negative;
			st_next.tap_axis_reg = st_reg.tap_axis_reg | i_tap.axis;
			if (i_odr_tick && st_reg.tap_len_reg != 8'hff) begin
				st_next.tap_len_reg = st_reg.tap_len_reg + 8'h01;
			end
		end else begin
			st_next.tap_len_reg = '0;
			st_next.tap_seen_reg = 1'b0;
			st_next.tap_axis_reg = '0;
		end
		// Register writes
		if (i_bus.wr) begin
			unique case (i_bus.addr)
				`TAD_OFS_CFG: st_next.cfg_reg = i_bus.wdata[5:0];
				`TAD_OFS_THS: begin
					st_next.latch_reg = i_bus.wdata[`TAD_BIT_LATCH];
					st_next.ths_reg = i_bus.wdata[6:0];
				end
				`TAD_OFS_LIMIT: st_next.limit_reg = i_bus.wdata[6:0];
				`TAD_OFS_LATENCY: st_next.latency_reg = i_bus.wdata;
				`TAD_OFS_WINDOW: st_next.window_reg = i_bus.wdata;
				`TAD_OFS_WAKE_THS: st_next.wake_ths_reg = i_bus.wdata[6:0];
				`TAD_OFS_WAKE_DUR: st_next.wake_dur_reg = i_bus.wdata;
				default: ;
			endcase
		end
		// Register reads
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				`TAD_OFS_CFG: st_next.rdata_reg = {2'b00, st_reg.cfg_reg};
				`TAD_OFS_STATUS: st_next.rdata_reg = status_byte;
				`TAD_OFS_THS: st_next.rdata_reg = {st_reg.latch_reg, st_reg.ths_reg};
				`TAD_OFS_LIMIT: st_next.rdata_reg = {1'b0, st_reg.limit_reg};
				`TAD_OFS_LATENCY: st_next.rdata_reg = st_reg.latency_reg;
				`TAD_OFS_WINDOW: st_next.rdata_reg = st_reg.window_reg;
				`TAD_OFS_WAKE_THS: st_next.rdata_reg = {1'b0, st_reg.wake_ths_reg};
				`TAD_OFS_WAKE_DUR: st_next.rdata_reg = st_reg.wake_dur_reg;
				default: st_next.rdata_reg = `TAD_RST_BYTE;
			endcase
		end
		// Reading status releases a latched interrupt
		if (status_rd) begin
			st_next.ia_reg = 1'b0;
			if (st_reg.latch_reg) begin
				st_next.irq_reg = 1'b0;
			end
		end
		// Unlatched interrupt ends with the latency, or with the double-tap window if one follows
		if (!st_reg.latch_reg && st_reg.irq_reg && !gate_busy && st_reg.fsm_reg != TAD_GAP) begin
			st_next.irq_reg = 1'b0;
		end
		// Tap sequencing; a new event wins over a clearing read
		unique case (st_reg.fsm_reg)
			TAD_IDLE: begin
				if (tap_end && (hit_single != '0 || hit_double != '0)) begin
					st_next.sign_reg = st_reg.tap_neg_reg;
					st_next.axis_reg = st_reg.tap_axis_reg;
					st_next.sgl_reg = hit_single != '0;
					st_next.dbl_reg = 1'b0;
					gate_load = 1'b1;
					gate_count = {1'b0, st_reg.latency_reg};
					if (hit_single != '0) begin
						st_next.ia_reg = 1'b1;
						st_next.irq_reg = 1'b1;
					end
					if (hit_double != '0) begin
						st_next.fsm_reg = TAD_GAP;
					end
				end
			end
			TAD_GAP: begin
				if (!gate_busy && !gate_load) begin
					gate_load = 1'b1;
					gate_count = {1'b0, st_reg.window_reg};
					st_next.fsm_reg = TAD_WIN;
				end
			end
			TAD_WIN: begin
				if (tap_end && hit_double != '0) begin
					st_next.dbl_reg = 1'b1;
					st_next.sign_reg = st_reg.tap_neg_reg;
					st_next.axis_reg = st_reg.tap_axis_reg;
					st_next.ia_reg = 1'b1;
					st_next.irq_reg = 1'b1;
					gate_load = 1'b1;
					gate_count = {1'b0, st_reg.latency_reg};
					st_next.fsm_reg = TAD_IDLE;
				end else if (!gate_busy) begin
					st_next.fsm_reg = TAD_IDLE;
				end
			end
			default: st_next.fsm_reg = TAD_IDLE;
		endcase
		st_next.wake_reg = wake_done;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rdata = st_reg.rdata_reg;
	assign o_tap_irq = st_reg.irq_reg;
	assign o_wake = st_reg.wake_reg;
	assign o_tap_threshold = st_reg.ths_reg;
	assign o_wake_threshold = st_reg.wake_ths_reg;

	latched_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.latch_reg && o_tap_irq && !$past(status_rd) && !status_rd |=> o_tap_irq)
		else $error("latched tap interrupt dropped without status read");
	read_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
		status_rd && st_reg.latch_reg && st_reg.fsm_reg == TAD_IDLE && !tap_end |=> !o_tap_irq)
		else $error("status read did not release latched interrupt");
	ia_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_tap_irq) |-> st_reg.ia_reg)
		else $error("interrupt without active bit");
	unlatched_end_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!st_reg.latch_reg && o_tap_irq && !gate_busy && st_reg.fsm_reg == TAD_IDLE && !tap_end |=> !o_tap_irq)
		else $error("unlatched interrupt outlived latency");
	limit_top_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_bus.rd && i_bus.addr == `TAD_OFS_LIMIT |=> !o_rdata[7])
		else $error("time limit top bit not zero");
	ths_store_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_bus.wr && i_bus.addr == `TAD_OFS_THS |=> o_tap_threshold == $past(i_bus.wdata[6:0]))
		else $error("threshold not stored");
	wake_ths_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_bus.wr && i_bus.addr == `TAD_OFS_WAKE_THS |=> o_wake_threshold == $past(i_bus.wdata[6:0]))
		else $error("wake threshold not stored");
	wake_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_activity ##1 !i_activity |=> !o_wake)
		else $error("wake held without activity");
	gated_tap_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_IDLE && st_reg.cfg_reg == '0 && !o_tap_irq |=> !o_tap_irq)
		else $error("tap interrupt with all axes disabled");
	ia_read_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
		status_rd && !tap_end |=> !st_reg.ia_reg)
		else $error("active bit not cleared by status read");
	ia_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.ia_reg && !status_rd |=> st_reg.ia_reg)
		else $error("active bit lost without status read");
	status_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
		status_rd |=> o_rdata == $past(status_byte))
		else $error("status read returned a stale byte");
	sign_store_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_IDLE && tap_end && (hit_single != '0 || hit_double != '0)
		|=> st_reg.sign_reg == $past(st_reg.tap_neg_reg))
		else $error("tap sign not recorded");
	axis_store_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_IDLE && tap_end && (hit_single != '0 || hit_double != '0)
		|=> st_reg.axis_reg == $past(st_reg.tap_axis_reg))
		else $error("tap axes not recorded");
	single_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_IDLE && tap_end && (hit_single != '0 || hit_double != '0)
		|=> st_reg.sgl_reg == ($past(hit_single) != 3'h0))
		else $error("single tap bit wrong");
	single_irq_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_IDLE && tap_end && hit_single != '0 |=> o_tap_irq && st_reg.ia_reg)
		else $error("single tap raised no interrupt");
	double_wait_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_IDLE && tap_end && hit_single == '0 && hit_double != '0 |=> st_reg.fsm_reg == TAD_GAP)
		else $error("first of a double tap not awaited");
	gap_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_GAP && gate_busy |=> st_reg.fsm_reg == TAD_GAP)
		else $error("latency cut short");
	gap_open_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_GAP && !gate_busy |=> st_reg.fsm_reg == TAD_WIN)
		else $error("window not opened after latency");
	gap_ignore_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_GAP && !st_reg.dbl_reg |=> !st_reg.dbl_reg)
		else $error("double tap taken inside latency");
	double_hit_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_WIN && tap_end && hit_double != '0
		|=> st_reg.dbl_reg && st_reg.ia_reg && o_tap_irq && st_reg.fsm_reg == TAD_IDLE)
		else $error("second tap in window not reported");
	window_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_WIN && gate_busy && !tap_end |=> st_reg.fsm_reg == TAD_WIN)
		else $error("window closed early");
	window_close_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_WIN && !gate_busy && !tap_end |=> st_reg.fsm_reg == TAD_IDLE)
		else $error("window outlived its length");
	long_tap_a: assert property (@(posedge i_clk) disable iff (i_rst)
		st_reg.fsm_reg == TAD_IDLE && st_reg.tap_len_reg > {1'b0, st_reg.limit_reg} && !o_tap_irq |=> !o_tap_irq)
		else $error("over-long tap raised an interrupt");
	unlatched_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!st_reg.latch_reg && o_tap_irq && gate_busy |=> o_tap_irq)
		else $error("unlatched interrupt ended inside latency");
	limit_store_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_bus.wr && i_bus.addr == `TAD_OFS_LIMIT |=> st_reg.limit_reg == $past(i_bus.wdata[6:0]))
		else $error("time limit not stored");
	latency_store_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_bus.wr && i_bus.addr == `TAD_OFS_LATENCY |=> st_reg.latency_reg == $past(i_bus.wdata))
		else $error("latency not stored");
	latch_store_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_bus.wr && i_bus.addr == `TAD_OFS_THS |=> st_reg.latch_reg == $past(i_bus.wdata[`TAD_BIT_LATCH]))
		else $error("latch request not stored");
	cfg_store_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_bus.wr && i_bus.addr == `TAD_OFS_CFG |=> st_reg.cfg_reg == $past(i_bus.wdata[5:0]))
		else $error("tap enables not stored");
	wake_dur_store_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_bus.wr && i_bus.addr == `TAD_OFS_WAKE_DUR |=> st_reg.wake_dur_reg == $past(i_bus.wdata))
		else $error("wake duration not stored");
	wake_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
		wake_done |=> o_wake)
		else $error("wake output missed the duration count");
endmodule : tad_regs

// [sim/tad_host.sv]
// Host processor model issuing single-byte register accesses
`timescale 1ns/10ps
module tad_host (
	// Clock
	input wire logic i_clk,
	// Register bus
	input wire logic [7:0] i_rdata,
	output tad_pkg::tad_bus_t o_bus
);
	import tad_pkg::*;
	initial o_bus = '0;
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_bus = '{1'b1, 1'b0, a, d};
		@(negedge i_clk);
		o_bus = '{1'b0, 1'b0, ~a, ~d};
	endtask : wr
	// A status read is what releases a latched interrupt
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_bus = '{1'b0, 1'b1, a, 8'h00};
		@(negedge i_clk);
		o_bus = '{1'b0, 1'b0, ~a, 8'hff};
		d = i_rdata;
	endtask : rd
endmodule : tad_host

// [sim/tad_regs_bench.sv]
// Self-checking bench of the tap and activity register bank
`timescale 1ns/10ps
module tad_regs_bench;
	import tad_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_odr_tick = 1'b0;
	logic i_activity = 1'b0;
	tad_tap_t i_tap = '0;
	tad_bus_t bus;
	logic [7:0] o_rdata;
	logic [7:0] rv;
	logic o_tap_irq;
	logic o_wake;
	logic [6:0] o_tap_threshold;
	logic [6:0] o_wake_threshold;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	int seed = 32'hc80d;
	int shadow [int];
	always #4 i_clk = ~i_clk;
	tad_host host (.i_clk(i_clk), .i_rdata(o_rdata), .o_bus(bus));
	tad_regs uut (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(o_rdata),
		.i_odr_tick(i_odr_tick), .i_tap(i_tap), .i_activity(i_activity), .o_tap_irq(o_tap_irq),
		.o_wake(o_wake), .o_tap_threshold(o_tap_threshold), .o_wake_threshold(o_wake_threshold));
	task stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Data-rate ticks spaced so registered outputs settle between them
	task tick(input int n);
		repeat (n) begin
			@(negedge i_clk);
			i_odr_tick = 1'b1;
			@(negedge i_clk);
			i_odr_tick = 1'b0;
			repeat (2) @(negedge i_clk);
		end
	endtask : tick
	task tap(input logic neg, input logic [2:0] axis);
		@(negedge i_clk);
		i_tap = '{1'b1, neg, axis};
		@(negedge i_clk);
		i_tap = '0;
		repeat (2) @(negedge i_clk);
	endtask : tap
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			stop_test();
		end
	end
	initial begin
		repeat (3) @(negedge i_clk);
		i_rst = 1'b0;
		host.rd(8'h39, rv);
		chk("status reset", 8'h00, rv);
		host.rd(8'h3b, rv);
		chk("limit reset", 8'h00, rv);
		host.rd(8'h3c, rv);
		chk("latency reset", 8'h00, rv);
		host.rd(8'h3a, rv);
		chk("threshold reset", 8'h00, rv & 8'h7f);
		for (int a = 8'h3a; a <= 8'h3f; a++) begin
			shadow[a] = $random(seed) & 8'hff;
			host.wr(a[7:0], shadow[a][7:0]);
			if (a == 8'h3b || a == 8'h3e) shadow[a] &= 8'h7f;
		end
		host.wr(8'h39, 8'($random(seed)));
		for (int a = 8'h38; a <= 8'h40; a++) begin
			host.rd(a[7:0], rv);
			chk("register", shadow.exists(a) ? shadow[a][7:0] : 8'h00, rv);
		end
		chk("tap threshold out", {1'b0, shadow[8'h3a][6:0]}, {1'b0, o_tap_threshold});
		chk("wake threshold out", {1'b0, shadow[8'h3e][6:0]}, {1'b0, o_wake_threshold});
		$display("test registers done");
		host.wr(8'h38, 8'h01);
		host.wr(8'h3a, 8'h05);
		host.wr(8'h3b, 8'h05);
		host.wr(8'h3c, 8'h02);
		host.wr(8'h3d, 8'h00);
		tap(1'b0, 3'b010);
		chk("irq disabled axis", 8'h00, {7'h00, o_tap_irq});
		tick(3);
		host.rd(8'h39, rv);
		i_tap = '{1'b1, 1'b0, 3'b001};
		tick(6);
		i_tap = '0;
		repeat (2) @(negedge i_clk);
		chk("long tap rejected", 8'h00, {7'h00, o_tap_irq});
		tap(1'b1, 3'b001);
		chk("irq raised", 8'h01, {7'h00, o_tap_irq});
		tick(1);
		chk("irq in latency", 8'h01, {7'h00, o_tap_irq});
		tick(2);
		chk("irq released", 8'h00, {7'h00, o_tap_irq});
		host.rd(8'h39, rv);
		chk("status single", 8'h59, rv);
		host.rd(8'h39, rv);
		chk("status cleared", 8'h00, rv & 8'h40);
		$display("test unlatched tap done");
		host.wr(8'h3a, 8'h85);
		tap(1'b0, 3'b001);
		tick(5);
		chk("irq latched", 8'h01, {7'h00, o_tap_irq});
		host.rd(8'h39, rv);
		chk("status latched", 8'h51, rv);
		@(negedge i_clk);
		chk("irq after read", 8'h00, {7'h00, o_tap_irq});
		$display("test latched tap done");
		host.wr(8'h38, 8'h02);
		host.wr(8'h3a, 8'h05);
		host.wr(8'h3d, 8'h04);
		tap(1'b0, 3'b001);
		chk("first of double", 8'h00, {7'h00, o_tap_irq});
		tap(1'b0, 3'b001);
		chk("tap in latency", 8'h00, {7'h00, o_tap_irq});
		tick(2);
		tap(1'b1, 3'b001);
		chk("double irq", 8'h01, {7'h00, o_tap_irq});
		host.rd(8'h39, rv);
		chk("status double", 8'h69, rv);
		tick(2);
		chk("double released", 8'h00, {7'h00, o_tap_irq});
		tap(1'b0, 3'b001);
		tick(6);
		tap(1'b0, 3'b001);
		chk("late second tap", 8'h00, {7'h00, o_tap_irq});
		$display("test double tap done");
		host.wr(8'h3f, 8'h01);
		i_activity = 1'b1;
		tick(8);
		chk("wake early", 8'h00, {7'h00, o_wake});
		tick(1);
		chk("wake after 9", 8'h01, {7'h00, o_wake});
		$display("test wake duration done");
		stop_test();
	end
endmodule : tad_regs_bench
